// *** design/afm_format_select.sv ***
// output byte order, code format, conversion mode and port select logic with wishbone registers
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module afm_format_select #(
  parameter int LIMIT_W = 24,
  parameter logic [23:0] IDLE_LIMIT_DEF = 24'(afm_pkg::IDLE_LIMIT_CYC)
)(
  input wire logic mclk,
  input wire logic rst,
  // conversion result from the converter core
  input wire logic [15:0] result_in,
  input wire logic result_valid,
  // static select pins
  input wire logic byte_order_select,
  input wire logic output_code_select,
  input wire logic fastest_mode_select,
  input wire logic low_power_mode_select,
  input wire logic serial_parallel_select,
  // parallel data bus, two signals per line
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  // mode indications to the converter core
  output logic [1:0] power_mode,
  output logic serial_mode,
  output logic accuracy_lost,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // formats one result word; used for the bus drive and the result register
  function automatic logic [15:0] fmt_word(
    input logic [15:0] raw,
    input logic binary,
    input logic swap
  );
    logic [15:0] v;
    v = raw;
    if (!binary)
    begin
      v[15] = ~raw[15];
    end
    fmt_word = swap ? {v[7:0], v[15:8]} : v;
  endfunction : fmt_word

  logic [15:0] raw_ff;
  logic [15:0] data_ff;
  logic [15:0] oe_ff;
  logic [1:0] mode_ff;
  logic serial_ff;
  logic lost_ff;
  logic out_en_ff;
  logic [LIMIT_W-1:0] limit_ff;
  logic [LIMIT_W-1:0] idle_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  afm_pkg::afm_mode_t nxt_mode;
  logic bus_req;
  logic wr_ctrl;
  logic wr_limit;
  logic wr_status;
  logic clr_lost;
  logic idle_over;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_ctrl = bus_req && wb_we_i && wb_adr_i == afm_pkg::ADDR_CTRL && wb_sel_i[0];
  assign wr_limit = bus_req && wb_we_i && wb_adr_i == afm_pkg::ADDR_RATE_LIMIT;
  assign wr_status = bus_req && wb_we_i && wb_adr_i == afm_pkg::ADDR_STATUS && wb_sel_i[0];
  assign clr_lost = wr_status && wb_dat_i[afm_pkg::STAT_LOST_BIT];
  assign idle_over = idle_ff >= limit_ff;

  // mode decode; both selects high is not a documented combination, so it falls back to normal
  always_comb
  begin
    case ({fastest_mode_select, low_power_mode_select})
      2'b10: nxt_mode = afm_pkg::AFM_MODE_FAST;
      2'b01: nxt_mode = afm_pkg::AFM_MODE_LOWPWR;
      default: nxt_mode = afm_pkg::AFM_MODE_NORMAL;
    endcase
  end

  // captured conversion result
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      raw_ff <= afm_pkg::RESULT_RESET;
    else if (result_valid)
      raw_ff <= result_in;
  end

  // data lines reformatted every cycle so a pin change shows one cycle later
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      data_ff <= afm_pkg::RESULT_RESET;
    else
      data_ff <= fmt_word(raw_ff, output_code_select, byte_order_select);
  end

  // port select: serial mode releases the parallel lines to the serial port logic
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      oe_ff <= 16'h0000;
      serial_ff <= 1'b0;
    end
    else
    begin
      serial_ff <= serial_parallel_select;
      oe_ff <= {16{!serial_parallel_select && out_en_ff}};
    end
  end

  // registered operating mode for the converter core
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mode_ff <= afm_pkg::AFM_MODE_NORMAL;
    else
      mode_ff <= nxt_mode;
  end

  // cycles since the last conversion, saturating; host must keep it under the limit
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      idle_ff <= '0;
    else if (result_valid)
      idle_ff <= '0;
    else if (!idle_over)
      idle_ff <= idle_ff + 1'b1;
  end

  // accuracy lost flag: only fastest mode has a minimum rate; a new event beats the clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      lost_ff <= 1'b0;
    else if (nxt_mode == afm_pkg::AFM_MODE_FAST && idle_over && !result_valid)
      lost_ff <= 1'b1;
    else if (clr_lost)
      lost_ff <= 1'b0;
  end

  // control register: parallel output enable
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      out_en_ff <= afm_pkg::CTRL_RESET[afm_pkg::CTRL_OUT_EN_BIT];
    else if (wr_ctrl)
      out_en_ff <= wb_dat_i[afm_pkg::CTRL_OUT_EN_BIT];
  end

  // idle limit register, byte lanes honoured
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      limit_ff <= IDLE_LIMIT_DEF[LIMIT_W-1:0];
    else if (wr_limit)
    begin
      for (int i = 0; i < LIMIT_W; i++)
      begin
        if (wb_sel_i[i/8])
          limit_ff[i] <= wb_dat_i[i];
      end
    end
  end

  // wishbone answer: one wait state, ack for one cycle, unmapped reads give zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        case (wb_adr_i)
          afm_pkg::ADDR_CTRL: rdata_ff <= {31'h0000_0000, out_en_ff};
          afm_pkg::ADDR_RATE_LIMIT: rdata_ff <= 32'(limit_ff);
          afm_pkg::ADDR_STATUS: rdata_ff <= {26'h000_0000, output_code_select,
            byte_order_select, serial_ff, mode_ff, lost_ff};
          afm_pkg::ADDR_RESULT: rdata_ff <= {16'h0000, data_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign data_out = data_ff;
  assign data_oe = oe_ff;
  assign power_mode = mode_ff;
  assign serial_mode = serial_ff;
  assign accuracy_lost = lost_ff;
  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;

  // checks next to the logic they guard
  order_plain_a: assert property (@(posedge mclk) disable iff (rst)
    !byte_order_select && output_code_select |=> data_out == $past(raw_ff))
    else $error("plain byte order wrong");

  order_swap_a: assert property (@(posedge mclk) disable iff (rst)
    byte_order_select && output_code_select
    |=> data_out == {$past(raw_ff[7:0]), $past(raw_ff[15:8])})
    else $error("swapped byte order wrong");

  code_binary_a: assert property (@(posedge mclk) disable iff (rst)
    output_code_select && !byte_order_select |=> data_out[15] == $past(raw_ff[15]))
    else $error("binary msb altered");

  code_twos_a: assert property (@(posedge mclk) disable iff (rst)
    !output_code_select && !byte_order_select
    |=> data_out[15] != $past(raw_ff[15]) && data_out[14:0] == $past(raw_ff[14:0]))
    else $error("twos complement msb not inverted");

  fast_lost_a: assert property (@(posedge mclk) disable iff (rst)
    fastest_mode_select && !low_power_mode_select && idle_over && !result_valid
    |=> accuracy_lost && power_mode == afm_pkg::AFM_MODE_FAST)
    else $error("missed minimum rate not flagged");

  normal_keep_a: assert property (@(posedge mclk) disable iff (rst)
    !fastest_mode_select && !accuracy_lost |=> !accuracy_lost)
    else $error("accuracy flag set outside fastest mode");

  low_power_a: assert property (@(posedge mclk) disable iff (rst)
    low_power_mode_select && !fastest_mode_select |=> power_mode == afm_pkg::AFM_MODE_LOWPWR)
    else $error("reduced power mode not selected");

  port_select_a: assert property (@(posedge mclk) disable iff (rst)
    !serial_parallel_select && out_en_ff |=> !serial_mode && data_oe == 16'hffff)
    else $error("parallel port not driven");

  low_lines_a: assert property (@(posedge mclk) disable iff (rst)
    serial_parallel_select |=> serial_mode && data_oe[1:0] == 2'b00)
    else $error("low lines driven in serial mode");

  ack_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // both mode pins high is not a documented pairing, so it must not reach fastest mode
  both_high_a: assert property (@(posedge mclk) disable iff (rst)
    fastest_mode_select && low_power_mode_select |=> power_mode == afm_pkg::AFM_MODE_NORMAL)
    else $error("both mode pins high left normal mode");

  normal_mode_a: assert property (@(posedge mclk) disable iff (rst)
    !fastest_mode_select && !low_power_mode_select |=> power_mode == afm_pkg::AFM_MODE_NORMAL)
    else $error("normal mode not selected");

  // a missed minimum rate must stay visible until software clears it
  lost_sticky_a: assert property (@(posedge mclk) disable iff (rst)
    accuracy_lost && !clr_lost |=> accuracy_lost)
    else $error("accuracy flag dropped without a clear");

  lost_clear_a: assert property (@(posedge mclk) disable iff (rst)
    clr_lost && !(fastest_mode_select && !low_power_mode_select && idle_over && !result_valid)
    |=> !accuracy_lost)
    else $error("accuracy flag not cleared");

  // idle count restarts on every result and parks at the limit instead of wrapping
  idle_restart_a: assert property (@(posedge mclk) disable iff (rst)
    result_valid |=> idle_ff == '0)
    else $error("idle count not restarted by a result");

  idle_park_a: assert property (@(posedge mclk) disable iff (rst)
    idle_over && !result_valid |=> idle_ff == $past(idle_ff))
    else $error("idle count moved past the limit");

  raw_capture_a: assert property (@(posedge mclk) disable iff (rst)
    result_valid |=> raw_ff == $past(result_in))
    else $error("conversion result not captured");

  twos_swap_a: assert property (@(posedge mclk) disable iff (rst)
    !output_code_select && byte_order_select
    |=> data_out[7] != $past(raw_ff[15]) && data_out[6:0] == $past(raw_ff[14:8]))
    else $error("twos complement msb lost in the swap");

  // parallel drivers off whenever software disabled them or the serial port owns the bus
  oe_disabled_a: assert property (@(posedge mclk) disable iff (rst)
    !out_en_ff |=> data_oe == 16'h0000)
    else $error("parallel lines driven while disabled");

  serial_release_a: assert property (@(posedge mclk) disable iff (rst)
    serial_parallel_select |=> data_oe == 16'h0000)
    else $error("parallel lines driven in serial mode");

  // register bus: every request answered one cycle later, reads with the addressed contents
  ack_answer_a: assert property (@(posedge mclk) disable iff (rst)
    bus_req |=> wb_ack_o)
    else $error("request not acknowledged");

  ctrl_write_a: assert property (@(posedge mclk) disable iff (rst)
    wr_ctrl |=> out_en_ff == $past(wb_dat_i[afm_pkg::CTRL_OUT_EN_BIT]))
    else $error("output enable not written");

  result_read_a: assert property (@(posedge mclk) disable iff (rst)
    bus_req && !wb_we_i && wb_adr_i == afm_pkg::ADDR_RESULT
    |=> wb_dat_o == {16'h0000, $past(data_out)})
    else $error("result register does not match the bus");

endmodule : afm_format_select

// *** design/afm_pkg.sv ***
// constants, register map and mode encoding for the output format and mode select block
// What this block does
// - byte order low: result low byte on lines 7..0, high byte on 15..8.
// - byte order high: halves swapped, low byte on 15..8, high on 7..0.
// - code select high: result leaves unmodified as straight offset binary.
// - code select low: result msb inverted, giving twos complement output.
// - fastest high, low power low: max throughput; host keeps a minimum conversion rate.
// - fastest low: full accuracy kept regardless of interval between conversions.
// - low power high, fastest low: reduced power mode, power tracks sampling rate.
// - serial/parallel low selects parallel port; high selects the serial interface.
// - lines 0 and 1 carry result bits in parallel mode, high impedance in serial.
package afm_pkg;

  // wishbone byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RATE_LIMIT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_RESULT = 4'hc;

  // control fields
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // status fields
  localparam int STAT_LOST_BIT = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int STAT_SERIAL_BIT = 3;
  localparam int STAT_SWAP_BIT = 4;
  localparam int STAT_BINARY_BIT = 5;

  // default longest idle gap in fastest mode: 1 ms at 25 MHz
  localparam int CLK_HZ = 25_000_000;
  localparam int IDLE_LIMIT_US = 1000;
  localparam int IDLE_LIMIT_CYC = IDLE_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // conversion operating mode, gray coded
  typedef enum logic [1:0]
  {
    AFM_MODE_NORMAL = 2'b00,
    AFM_MODE_FAST = 2'b01,
    AFM_MODE_LOWPWR = 2'b11
  } afm_mode_t;

endpackage : afm_pkg

// *** tb/afm_host_model.sv ***
// host side model that owns the static select pins
`timescale 1ns/1ns
module afm_host_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] want,
  input wire logic busy,
  output logic [4:0] pins
);
  // new pin levels land only between conversions, never mid readout
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pins <= 5'h00;
    else if (!busy)
      pins <= want;
  end
endmodule : afm_host_model

// *** tb/afm_format_select_test.sv ***
// self-checking bench for the output format and mode select block
`timescale 1ns/1ns
module afm_format_select_test;
  logic mclk = 0, rst = 1, rv = 0, cyc = 0, we = 0;
  logic [15:0] rin = 16'h0000;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, q;
  logic [4:0] want = 5'h00, pins;
  logic [15:0] d_o, d_oe;
  logic [1:0] pm;
  logic sm, lost, ack;
  logic [31:0] rdat;
  int n_fail = 0, num_checks = 0, seed = 13561, cycles = 0, e, m;
  // clock at 25 MHz
  always #20 mclk = ~mclk;
  afm_host_model host (.mclk(mclk), .rst(rst), .want(want), .busy(rv), .pins(pins));
  afm_format_select #(.IDLE_LIMIT_DEF(24'h00_03e8)) dut (.mclk(mclk), .rst(rst),
    .result_in(rin), .result_valid(rv), .byte_order_select(pins[0]),
    .output_code_select(pins[1]), .fastest_mode_select(pins[2]),
    .low_power_mode_select(pins[3]), .serial_parallel_select(pins[4]), .data_out(d_o),
    .data_oe(d_oe), .power_mode(pm), .serial_mode(sm), .accuracy_lost(lost),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // pin-level outputs
  task chk_pin(input string nm, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_pin
  // register read data
  task chk_reg(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_reg
  // classic single cycle; ack and read data are taken at the rising edge that samples ack high,
  // and only the hang guard ends a wait for an answer that never comes
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge mclk);
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  // main sequence; expectations come from integer arithmetic on the pin code
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    wb(0, afm_pkg::ADDR_CTRL, 0, q);
    chk_reg("ctrl reset", 32'h0000_0001, q);
    wb(0, afm_pkg::ADDR_RATE_LIMIT, 0, q);
    chk_reg("limit reset", 32'h0000_03e8, q);
    for (int i = 0; i < 32; i++)
    begin
      want <= i[4:0];
      repeat (2) @(posedge mclk);
      rin <= 16'($random(seed));
      rv <= 1'b1;
      @(posedge mclk);
      rv <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      e = i[1] ? rin : rin ^ 32'h8000;
      if (i[0])
        e = ((e & 255) << 8) | (e >> 8);
      m = (i[2] && !i[3]) ? 1 : (i[3] && !i[2]) ? 3 : 0;
      chk_pin("data", e[15:0], d_o);
      chk_pin("oe", i[4] ? 16'h0000 : 16'hffff, d_oe);
      chk_pin("mode", 16'(m), {14'h0000, pm});
      chk_pin("serial", 16'(i[4]), {15'h0000, sm});
      wb(0, afm_pkg::ADDR_RESULT, 0, q);
      chk_reg("result reg", 32'(e[15:0]), q);
      wb(0, afm_pkg::ADDR_STATUS, 0, q);
      chk_reg("status", 32'((i[1] << 5) | (i[0] << 4) | (i[4] << 3) | (m << 1)),
        q & 32'h0000_003e);
    end
    want <= 5'h00;
    wb(1, afm_pkg::ADDR_CTRL, 0, q);
    chk_pin("oe disabled", 16'h0000, d_oe);
    wb(1, 4'h2, 32'h0000_0001, q);
    wb(0, 4'h2, 0, q);
    chk_reg("unmapped", 32'h0000_0000, q);
    wb(1, afm_pkg::ADDR_CTRL, 1, q);
    wb(1, afm_pkg::ADDR_RATE_LIMIT, 8, q);
    wb(0, afm_pkg::ADDR_RATE_LIMIT, 0, q);
    chk_reg("limit", 32'h0000_0008, q);
    repeat (40) @(posedge mclk);
    chk_pin("lost normal", 16'h0000, {15'h0000, lost});
    want <= 5'h04;
    repeat (40) @(posedge mclk);
    chk_pin("lost fast", 16'h0001, {15'h0000, lost});
    want <= 5'h00;
    repeat (3) @(posedge mclk);
    wb(1, afm_pkg::ADDR_STATUS, 1, q);
    wb(0, afm_pkg::ADDR_STATUS, 0, q);
    chk_reg("lost cleared", 32'h0000_0000, q & 32'h0000_0001);
    conclude();
  end
endmodule : afm_format_select_test
